// [design/rtas_regs.svh]
`ifndef RTAS_REGS_SVH
`define RTAS_REGS_SVH

// ****************************************************************
// Clock and serial frame.
// ****************************************************************
`define RTAS_CLK_HZ 50000000
`define RTAS_SPI_BITS 16
`define RTAS_SCK_DIV 4

// ****************************************************************
// Filter IC programming addresses.
// ****************************************************************
`define RTAS_ADDR_DEV 8'h01
`define RTAS_ADDR_SUBFLT 8'h02
`define RTAS_ADDR_TXD 8'h03
`define RTAS_ADDR_PATH 8'h04
`define RTAS_ADDR_ATTEN 8'h05

// ****************************************************************
// Reset values.
// ****************************************************************
`define RTAS_ATTEN_RST 8'h00
`define RTAS_WORD_RST 16'h0000

// ****************************************************************
// Tone figures in hertz and strobe multipliers.
// ****************************************************************
`define RTAS_HG_SPLIT_HZ 1440
`define RTAS_MULT_SIX 6
`define RTAS_MULT_TWO 2
`define RTAS_LG0_HZ 697
`define RTAS_LG1_HZ 770
`define RTAS_LG2_HZ 852
`define RTAS_LG3_HZ 941
`define RTAS_HG0_HZ 1209
`define RTAS_HG1_HZ 1336
`define RTAS_HG2_HZ 1477
`define RTAS_ALERT_MIN_HZ 100
`define RTAS_ALERT_MAX_HZ 3000
`define RTAS_SAMP_MIN_HZ 1000
`define RTAS_SAMP_MAX_HZ 2000

`endif

// [design/rtas_pkg.sv]
package rtas_pkg;

  typedef enum logic [1:0] {
    OPT_EXT_PTT = 2'b00,
    OPT_EXT_SPK = 2'b01,
    OPT_MAN_DOWN = 2'b10,
    OPT_NORMAL = 2'b11
  } rtas_opt_mode_t;

  typedef enum logic [1:0] {
    SUB_NONE = 2'b00,
    SUB_TONE = 2'b01,
    SUB_CODE = 2'b10
  } rtas_sub_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SEND = 2'b01,
    SEQ_WAIT = 2'b10
  } rtas_seq_t;

  typedef enum logic [2:0] {
    JOB_DEV = 3'b000,
    JOB_FLT = 3'b001,
    JOB_TXD = 3'b010,
    JOB_PATH = 3'b011,
    JOB_ATTEN = 3'b100
  } rtas_job_t;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_LOW = 2'b01,
    SP_HIGH = 2'b10,
    SP_END = 2'b11
  } rtas_spi_st_t;

  // Half period in clock cycles of a strobe running at mult times freq_hz.
  function automatic int rtas_half(input int clk_hz, input int freq_hz, input int mult);
    return clk_hz / (2 * mult * freq_hz);
  endfunction

endpackage

// [design/rtas_spi_if.sv]
`timescale 1ns/1ps
interface rtas_spi_if;
  logic start;
  logic [15:0] word;
  logic busy;
  logic done;
  modport ctrl (output start, output word, input busy, input done);
  modport spi (input start, input word, output busy, output done);
endinterface

// [design/rtas_spi.sv]
`timescale 1ns/1ps
`include "rtas_regs.svh"
module rtas_spi #(
  parameter int SCK_DIV = `RTAS_SCK_DIV
) (
  input wire logic clk_i,     // System clock.
  input wire logic nrst_i,    // Asynchronous reset, active low.
  rtas_spi_if.spi bus,        // Word request from the sequencer.
  output logic spi_sck_o,     // Serial clock, idles low.
  output logic spi_mosi_o,    // Serial data, msb first.
  output logic spi_cs_n_o     // Filter IC select, active low.
);
  generate
    if (SCK_DIV < 1 || SCK_DIV > 255) begin : g_chk
      $error("rtas_spi: SCK_DIV out of range");
    end
  endgenerate

  localparam logic [7:0] DIV_LAST = 8'(SCK_DIV - 1);

  rtas_pkg::rtas_spi_st_t st_r, st_nxt;
  logic [7:0] div_r, div_nxt;
  logic [4:0] bit_r, bit_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic sck_r, sck_nxt;
  logic cs_n_r, cs_n_nxt;
  logic done_r, done_nxt;
  logic tick;

  assign tick = (div_r == DIV_LAST);

  always_comb begin
    st_nxt = st_r;
    div_nxt = tick ? 8'h00 : 8'(div_r + 8'h01);
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    sck_nxt = sck_r;
    cs_n_nxt = cs_n_r;
    done_nxt = 1'b0;
    unique case (st_r)
      rtas_pkg::SP_IDLE: begin
        div_nxt = 8'h00;
        if (bus.start) begin
          sh_nxt = bus.word;
          bit_nxt = 5'h00;
          cs_n_nxt = 1'b0;
          st_nxt = rtas_pkg::SP_LOW;
        end
      end
      rtas_pkg::SP_LOW: begin
        if (tick) begin
          sck_nxt = 1'b1;
          st_nxt = rtas_pkg::SP_HIGH;
        end
      end
      rtas_pkg::SP_HIGH: begin
        if (tick) begin
          sck_nxt = 1'b0;
          if (bit_r == 5'(`RTAS_SPI_BITS - 1)) begin
            st_nxt = rtas_pkg::SP_END;
          end else begin
            sh_nxt = {sh_r[14:0], 1'b0};
            bit_nxt = 5'(bit_r + 5'h01);
            st_nxt = rtas_pkg::SP_LOW;
          end
        end
      end
      rtas_pkg::SP_END: begin
        if (tick) begin
          cs_n_nxt = 1'b1;
          done_nxt = 1'b1;
          st_nxt = rtas_pkg::SP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= rtas_pkg::SP_IDLE;
      div_r <= 8'h00;
      bit_r <= 5'h00;
      sh_r <= `RTAS_WORD_RST;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      sck_r <= sck_nxt;
      cs_n_r <= cs_n_nxt;
      done_r <= done_nxt;
    end
  end

  assign bus.busy = (st_r != rtas_pkg::SP_IDLE);
  assign bus.done = done_r;
  assign spi_sck_o = sck_r;
  assign spi_mosi_o = sh_r[15];
  assign spi_cs_n_o = cs_n_r;
endmodule

// [design/rtas_ctrl.sv]
`timescale 1ns/1ps
`include "rtas_regs.svh"
module rtas_ctrl #(
  parameter int DIV_W = 20,
  parameter int ALERT_HALF_MIN = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_ALERT_MAX_HZ, 1),
  parameter int ALERT_HALF_MAX = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_ALERT_MIN_HZ, 1),
  parameter int SAMP_HALF_MIN = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_SAMP_MAX_HZ, 1),
  parameter int SAMP_HALF_MAX = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_SAMP_MIN_HZ, 1),
  parameter int LG_HALF0 = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_LG0_HZ, `RTAS_MULT_SIX),
  parameter int LG_HALF1 = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_LG1_HZ, `RTAS_MULT_SIX),
  parameter int LG_HALF2 = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_LG2_HZ, `RTAS_MULT_SIX),
  parameter int LG_HALF3 = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_LG3_HZ, `RTAS_MULT_SIX),
  parameter int HG_HALF0 = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_HG0_HZ,
    (`RTAS_HG0_HZ < `RTAS_HG_SPLIT_HZ) ? `RTAS_MULT_SIX : `RTAS_MULT_TWO),
  parameter int HG_HALF1 = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_HG1_HZ,
    (`RTAS_HG1_HZ < `RTAS_HG_SPLIT_HZ) ? `RTAS_MULT_SIX : `RTAS_MULT_TWO),
  parameter int HG_HALF2 = rtas_pkg::rtas_half(`RTAS_CLK_HZ, `RTAS_HG2_HZ,
    (`RTAS_HG2_HZ < `RTAS_HG_SPLIT_HZ) ? `RTAS_MULT_SIX : `RTAS_MULT_TWO)
) (
  input wire logic clk_i,                     // System clock, 50 MHz.
  input wire logic nrst_i,                    // Asynchronous reset, active low.
  input wire logic sub_tone_en_i,             // Send sub-audible tone.
  input wire logic sub_code_en_i,             // Send sub-audible code.
  input wire logic [DIV_W-1:0] sub_half_i,    // Sub-audible strobe half period.
  input wire logic [7:0] dev_level_i,         // Low-speed deviation setting.
  input wire logic sub_decode_en_i,           // Decoding sub-audible data.
  input wire logic [DIV_W-1:0] samp_half_i,   // Sampling wave half period.
  input wire logic dtmf_en_i,                 // Send dialling tone pair.
  input wire logic [1:0] dtmf_low_idx_i,      // Low-group tone 0..3.
  input wire logic [1:0] dtmf_high_idx_i,     // High-group tone 0..2.
  input wire logic fast_data_en_i,            // Send fast data.
  input wire logic [DIV_W-1:0] baud_half_i,   // Baud strobe half period.
  input wire logic [5:0] txd_gain_i,          // Data filter and gain setting.
  input wire logic alert_ext_en_i,            // Play external alert tone.
  input wire logic alert_int_en_i,            // Play internal alert tone.
  input wire logic [DIV_W-1:0] alert_half_i,  // Alert strobe half period.
  input wire logic [7:0] alert_level_i,       // Attenuator value for alerts.
  input wire logic [7:0] volume_sense_in_i,   // Sampled volume voltage.
  input wire logic volume_valid_i,            // New volume sample, one cycle.
  input wire logic constant_volume_mode_i,    // Constant volume mode.
  input wire logic [7:0] cvc_level_i,         // Attenuator value in that mode.
  input wire logic [7:0] ext_fixed_level_i,   // Attenuator value for adapter.
  input wire logic vehicular_adapter_i,       // Vehicular adapter detected.
  input wire logic squelch_detect_i,          // Squelch detect pin.
  input wire logic option_line_a_i,           // Option select pin a.
  input wire logic option_line_b_i,           // Option select pin b.
  input wire logic fast_data_in_i,            // Limited fast data pin.
  input wire logic slow_data_in_i,            // Limited slow data pin.
  output logic fast_data_o,                   // Synchronised fast data.
  output logic slow_data_o,                   // Synchronised slow data.
  output logic subaudible_strobe_out_o,       // Sub-audible strobe or sampling.
  output logic high_group_strobe_out_o,       // High-group or baud strobe.
  output logic low_group_strobe_out_o,        // Low-group strobe.
  output logic alert_strobe_out_o,            // Alert strobe, same line as low.
  output logic amp_en_o,                      // Amplifier enable, active high.
  output logic ext_spk_sel_n_o,               // External speaker, active low.
  output rtas_pkg::rtas_opt_mode_t opt_mode_o,// Decoded option mode.
  output logic spi_sck_o,                     // Serial clock.
  output logic spi_mosi_o,                    // Serial data.
  output logic spi_cs_n_o                     // Filter IC select, active low.
);
  generate
    if (DIV_W < 18 || DIV_W > 31 || ALERT_HALF_MAX >= (1 << DIV_W) || SAMP_HALF_MIN < 1) begin : g_chk
      $error("rtas_ctrl: divider width cannot hold the tone counts");
    end
  endgenerate

  // ****************************************************************
  // Pin synchronisers and option decoding.
  // ****************************************************************
  logic [4:0] meta_r, sync_r;
  rtas_pkg::rtas_opt_mode_t opt_r, opt_nxt;
  logic [7:0] vol_r, vol_nxt;
  logic squelch_detect;

  always_comb begin
    opt_nxt = rtas_pkg::rtas_opt_mode_t'({sync_r[1], sync_r[2]});
    vol_nxt = volume_valid_i ? volume_sense_in_i : vol_r;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Squelch detect resets to idle so that no false activity follows reset.
      meta_r <= 5'h1E;
      sync_r <= 5'h1E;
      opt_r <= rtas_pkg::OPT_NORMAL;
      vol_r <= `RTAS_ATTEN_RST;
    end else begin
      meta_r <= {slow_data_in_i, fast_data_in_i, option_line_b_i, option_line_a_i, squelch_detect_i};
      sync_r <= meta_r;
      opt_r <= opt_nxt;
      vol_r <= vol_nxt;
    end
  end

  assign squelch_detect = sync_r[0];
  assign fast_data_o = sync_r[3];
  assign slow_data_o = sync_r[4];
  assign opt_mode_o = opt_r;

  // ****************************************************************
  // Programming sequencer.
  // ****************************************************************
  rtas_spi_if spi_bus ();
  rtas_pkg::rtas_seq_t st_r, st_nxt;
  rtas_pkg::rtas_job_t job_r, job_nxt;
  rtas_pkg::rtas_sub_t sub_sel, sub_prog_r, sub_prog_nxt;
  logic [15:0] word_r, word_nxt;
  logic dev_done_r, dev_done_nxt;
  logic [1:0] txd_sel, txd_prog_r, txd_prog_nxt;
  logic [2:0] path_tgt, path_last_r, path_last_nxt;
  logic path_valid_r, path_valid_nxt;
  logic [7:0] atten_tgt, atten_last_r, atten_last_nxt;
  logic atten_valid_r, atten_valid_nxt;
  logic amp_r, amp_nxt;
  logic ext_r, ext_nxt;
  logic alert_on, audio_on, veh_rx, ext_want, path_ok, dtmf_run;

  assign sub_sel = sub_tone_en_i ? rtas_pkg::SUB_TONE :
                   (sub_code_en_i ? rtas_pkg::SUB_CODE : rtas_pkg::SUB_NONE);
  assign txd_sel = fast_data_en_i ? 2'b01 : (dtmf_en_i ? 2'b10 : 2'b00);
  assign alert_on = alert_ext_en_i | alert_int_en_i;
  assign audio_on = squelch_detect | alert_on;
  assign veh_rx = vehicular_adapter_i & squelch_detect;
  assign ext_want = (opt_r == rtas_pkg::OPT_EXT_SPK) | veh_rx;
  assign path_tgt = {ext_want, alert_on, squelch_detect};
  assign path_ok = path_valid_r & (path_last_r == path_tgt);
  assign atten_tgt = alert_on ? alert_level_i :
                     veh_rx ? ext_fixed_level_i :
                     constant_volume_mode_i ? cvc_level_i : vol_r;

  always_comb begin
    st_nxt = st_r;
    job_nxt = job_r;
    word_nxt = word_r;
    sub_prog_nxt = sub_prog_r;
    dev_done_nxt = dev_done_r;
    txd_prog_nxt = txd_prog_r;
    path_last_nxt = path_last_r;
    path_valid_nxt = path_valid_r;
    atten_last_nxt = atten_last_r;
    atten_valid_nxt = atten_valid_r;
    unique case (st_r)
      rtas_pkg::SEQ_IDLE: begin
        st_nxt = rtas_pkg::SEQ_SEND;
        if (sub_sel != rtas_pkg::SUB_NONE && sub_prog_r != sub_sel && !dev_done_r) begin
          job_nxt = rtas_pkg::JOB_DEV;
          word_nxt = {`RTAS_ADDR_DEV, dev_level_i};
        end else if (sub_sel != rtas_pkg::SUB_NONE && sub_prog_r != sub_sel) begin
          job_nxt = rtas_pkg::JOB_FLT;
          word_nxt = {`RTAS_ADDR_SUBFLT, 6'h00, sub_sel};
        end else if (txd_sel != 2'b00 && txd_prog_r != txd_sel) begin
          job_nxt = rtas_pkg::JOB_TXD;
          word_nxt = {`RTAS_ADDR_TXD, txd_gain_i, txd_sel};
        end else if (audio_on && !path_ok) begin
          job_nxt = rtas_pkg::JOB_PATH;
          word_nxt = {`RTAS_ADDR_PATH, 5'h00, path_tgt};
        end else if (audio_on && (!atten_valid_r || atten_last_r != atten_tgt)) begin
          job_nxt = rtas_pkg::JOB_ATTEN;
          word_nxt = {`RTAS_ADDR_ATTEN, atten_tgt};
        end else begin
          st_nxt = rtas_pkg::SEQ_IDLE;
        end
      end
      rtas_pkg::SEQ_SEND: begin
        st_nxt = rtas_pkg::SEQ_WAIT;
      end
      rtas_pkg::SEQ_WAIT: begin
        if (spi_bus.done) begin
          st_nxt = rtas_pkg::SEQ_IDLE;
          unique case (job_r)
            rtas_pkg::JOB_DEV: dev_done_nxt = 1'b1;
            rtas_pkg::JOB_FLT: sub_prog_nxt = rtas_pkg::rtas_sub_t'(word_r[1:0]);
            rtas_pkg::JOB_TXD: txd_prog_nxt = word_r[1:0];
            rtas_pkg::JOB_PATH: begin
              path_last_nxt = word_r[2:0];
              path_valid_nxt = 1'b1;
            end
            rtas_pkg::JOB_ATTEN: begin
              atten_last_nxt = word_r[7:0];
              atten_valid_nxt = 1'b1;
            end
            default: st_nxt = rtas_pkg::SEQ_IDLE;
          endcase
        end
      end
      default: st_nxt = rtas_pkg::SEQ_IDLE;
    endcase
    // Dropping a request forgets its programming so a restart sends it again.
    if (sub_sel == rtas_pkg::SUB_NONE) begin
      sub_prog_nxt = rtas_pkg::SUB_NONE;
      dev_done_nxt = 1'b0;
    end
    if (txd_sel == 2'b00) begin
      txd_prog_nxt = 2'b00;
    end
    if (!audio_on) begin
      path_valid_nxt = 1'b0;
      atten_valid_nxt = 1'b0;
    end
    amp_nxt = audio_on & path_ok & atten_valid_r & (amp_r | (atten_last_r == atten_tgt));
    ext_nxt = ext_want;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= rtas_pkg::SEQ_IDLE;
      job_r <= rtas_pkg::JOB_DEV;
      word_r <= `RTAS_WORD_RST;
      sub_prog_r <= rtas_pkg::SUB_NONE;
      dev_done_r <= 1'b0;
      txd_prog_r <= 2'b00;
      path_last_r <= 3'h0;
      path_valid_r <= 1'b0;
      atten_last_r <= `RTAS_ATTEN_RST;
      atten_valid_r <= 1'b0;
      amp_r <= 1'b0;
      ext_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      job_r <= job_nxt;
      word_r <= word_nxt;
      sub_prog_r <= sub_prog_nxt;
      dev_done_r <= dev_done_nxt;
      txd_prog_r <= txd_prog_nxt;
      path_last_r <= path_last_nxt;
      path_valid_r <= path_valid_nxt;
      atten_last_r <= atten_last_nxt;
      atten_valid_r <= atten_valid_nxt;
      amp_r <= amp_nxt;
      ext_r <= ext_nxt;
    end
  end

  assign spi_bus.start = (st_r == rtas_pkg::SEQ_SEND);
  assign spi_bus.word = word_r;
  assign amp_en_o = amp_r;
  assign ext_spk_sel_n_o = ~ext_r;

  rtas_spi u_spi (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .bus(spi_bus),
    .spi_sck_o(spi_sck_o),
    .spi_mosi_o(spi_mosi_o),
    .spi_cs_n_o(spi_cs_n_o)
  );

  // ****************************************************************
  // Strobe generators: sub-audible, high group, low group.
  // ****************************************************************
  logic [DIV_W-1:0] half [3];
  logic [2:0] run;
  logic [2:0] lvl;
  logic [DIV_W-1:0] lg_half, hg_half, samp_c, alert_c;

  always_comb begin
    unique case (dtmf_low_idx_i)
      2'b00: lg_half = DIV_W'(LG_HALF0);
      2'b01: lg_half = DIV_W'(LG_HALF1);
      2'b10: lg_half = DIV_W'(LG_HALF2);
      2'b11: lg_half = DIV_W'(LG_HALF3);
    endcase
    unique case (dtmf_high_idx_i)
      2'b00: hg_half = DIV_W'(HG_HALF0);
      2'b01: hg_half = DIV_W'(HG_HALF1);
      default: hg_half = DIV_W'(HG_HALF2);
    endcase
    samp_c = (samp_half_i < DIV_W'(SAMP_HALF_MIN)) ? DIV_W'(SAMP_HALF_MIN) :
             (samp_half_i > DIV_W'(SAMP_HALF_MAX)) ? DIV_W'(SAMP_HALF_MAX) : samp_half_i;
    alert_c = (alert_half_i < DIV_W'(ALERT_HALF_MIN)) ? DIV_W'(ALERT_HALF_MIN) :
              (alert_half_i > DIV_W'(ALERT_HALF_MAX)) ? DIV_W'(ALERT_HALF_MAX) : alert_half_i;
  end

  assign dtmf_run = (txd_sel == 2'b10) && (txd_prog_r == 2'b10);
  assign run[0] = ((sub_sel != rtas_pkg::SUB_NONE) && (sub_prog_r == sub_sel)) |
                  ((sub_sel == rtas_pkg::SUB_NONE) && sub_decode_en_i);
  assign half[0] = (sub_sel != rtas_pkg::SUB_NONE) ? sub_half_i : samp_c;
  assign run[1] = ((txd_sel == 2'b01) && (txd_prog_r == 2'b01)) | dtmf_run;
  assign half[1] = (txd_sel == 2'b01) ? baud_half_i : hg_half;
  assign run[2] = dtmf_run | (alert_ext_en_i & path_ok);
  assign half[2] = dtmf_run ? lg_half : alert_c;

  for (genvar i = 0; i < 3; i++) begin : g_gen
    logic [DIV_W-1:0] cnt_r, cnt_nxt;
    logic lvl_r, lvl_nxt;
    always_comb begin
      cnt_nxt = DIV_W'(cnt_r + DIV_W'(1));
      lvl_nxt = lvl_r;
      if (!run[i]) begin
        cnt_nxt = '0;
        lvl_nxt = 1'b0;
      end else if (cnt_r >= DIV_W'(half[i] - DIV_W'(1))) begin
        cnt_nxt = '0;
        lvl_nxt = ~lvl_r;
      end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cnt_r <= '0;
        lvl_r <= 1'b0;
      end else begin
        cnt_r <= cnt_nxt;
        lvl_r <= lvl_nxt;
      end
    end
    assign lvl[i] = lvl_r;
  end

  assign subaudible_strobe_out_o = lvl[0];
  assign high_group_strobe_out_o = lvl[1];
  assign low_group_strobe_out_o = lvl[2];
  assign alert_strobe_out_o = lvl[2];
endmodule

// [verification/rtas_fic_model.sv]
`timescale 1ns/1ps
// ****
// Filter IC model: collects programming words, returns limited data.
// ****
module rtas_fic_model (
  input wire logic spi_sck_i,  // Serial clock.
  input wire logic spi_mosi_i, // Serial data.
  input wire logic spi_cs_n_i, // Select, active low.
  input wire logic fd_raw_i,   // Recovered fast data.
  input wire logic sd_raw_i,   // Recovered slow data.
  output logic fdat_o,         // Limited fast data.
  output logic sdat_o,         // Limited slow data.
  output logic [15:0] word_o,  // Last whole word.
  output logic word_stb_o      // Toggles per word.
);
  localparam int ALERT_HZ [3] = '{300, 900, 1800};
  int n = 0;
  logic [15:0] sh;
  initial word_stb_o = 1'b0;
  always @(negedge spi_cs_n_i) n <= 0;
  always @(posedge spi_sck_i) if (!spi_cs_n_i) begin
    sh <= {sh[14:0], spi_mosi_i};
    n <= n + 1;
  end
  // A frame that is not exactly one word long is dropped, so the bench sees it missing.
  always @(posedge spi_cs_n_i) if (n == 16) begin
    word_o <= sh;
    word_stb_o <= ~word_stb_o;
  end
  assign fdat_o = fd_raw_i ? 1'b1 : 1'b0;
  assign sdat_o = sd_raw_i ? 1'b1 : 1'b0;
endmodule

// [verification/rtas_ctrl_sva.sv]
`timescale 1ns/1ps
// ****
// Port checks.
// ****
module rtas_ctrl_chk (
  input wire logic clk_i, // Clock.
  input wire logic nrst_i, // Reset.
  input wire logic sub_tone_en_i, // In.
  input wire logic sub_code_en_i, // In.
  input wire logic sub_decode_en_i, // In.
  input wire logic dtmf_en_i, // In.
  input wire logic fast_data_en_i, // In.
  input wire logic alert_ext_en_i, // In.
  input wire logic alert_int_en_i, // In.
  input wire logic squelch_detect_i, // In.
  input wire logic option_line_a_i, // In.
  input wire logic option_line_b_i, // In.
  input wire logic fast_data_in_i, // In.
  input wire logic slow_data_in_i, // In.
  input wire logic fast_data_o, // Out.
  input wire logic slow_data_o, // Out.
  input wire logic subaudible_strobe_out_o, // Out.
  input wire logic high_group_strobe_out_o, // Out.
  input wire logic low_group_strobe_out_o, // Out.
  input wire logic alert_strobe_out_o, // Out.
  input wire logic amp_en_o, // Out.
  input wire logic ext_spk_sel_n_o, // Out.
  input wire logic [1:0] opt_mode_o, // Out.
  input wire logic spi_sck_o, // Out.
  input wire logic spi_mosi_o, // Out.
  input wire logic spi_cs_n_o // Out.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  AST_SCK_IDLE: assert property (spi_cs_n_o |-> !spi_sck_o) else $error("sck off frame");
  AST_MOSI_HOLD: assert property (spi_sck_o && $past(spi_sck_o) |-> $stable(spi_mosi_o))
    else $error("mosi moved");
  AST_SUB_FIRST: assert property ($rose(sub_tone_en_i) && !$past(sub_code_en_i) && !sub_decode_en_i
    && !subaudible_strobe_out_o |=> !subaudible_strobe_out_o [*8]) else $error("early strobe");
  AST_SUB_STOP: assert property ((!sub_tone_en_i && !sub_code_en_i && !sub_decode_en_i) [*3]
    |-> !subaudible_strobe_out_o) else $error("sub strobe idle");
  AST_HG_STOP: assert property ((!dtmf_en_i && !fast_data_en_i) [*3] |-> !high_group_strobe_out_o)
    else $error("high strobe idle");
  AST_SHARED: assert property (alert_strobe_out_o == low_group_strobe_out_o) else $error("shared line");
  AST_AMP_OFF: assert property ((!squelch_detect_i && !alert_ext_en_i && !alert_int_en_i) [*5] |-> !amp_en_o)
    else $error("amp on");
  AST_AMP_AFTER: assert property ($rose(amp_en_o) |-> spi_cs_n_o && $past(spi_cs_n_o))
    else $error("amp mid frame");
  AST_OPT: assert property ($stable({option_line_a_i, option_line_b_i}) [*5]
    |-> opt_mode_o == {option_line_a_i, option_line_b_i}) else $error("option decode");
  AST_SPK: assert property ((opt_mode_o == rtas_pkg::OPT_EXT_SPK) [*2] |-> !ext_spk_sel_n_o)
    else $error("speaker select");
  AST_SYNC: assert property (fast_data_o == $past(fast_data_in_i, 2)) else $error("fast data");
  AST_SLOW_SYNC: assert property (slow_data_o == $past(slow_data_in_i, 2)) else $error("slow data");
endmodule
bind rtas_ctrl rtas_ctrl_chk u_chk (.*);

// [verification/tb_top.sv]
`timescale 1ns/1ps
// ****
// Bench for the tone, strobe and audio controller.
// ****
module tb_top;
  logic clk_i, nrst_i, sub_tone_en_i, sub_code_en_i, sub_decode_en_i, dtmf_en_i, fast_data_en_i, stb;
  logic alert_ext_en_i, alert_int_en_i, volume_valid_i, constant_volume_mode_i, vehicular_adapter_i;
  logic squelch_detect_i, option_line_a_i, option_line_b_i, fd_raw, sd_raw;
  logic [19:0] sub_half_i, samp_half_i, baud_half_i, alert_half_i;
  logic [7:0] dev_level_i, alert_level_i, volume_sense_in_i, cvc_level_i, ext_fixed_level_i, v, c, e;
  logic [5:0] txd_gain_i;
  logic [1:0] dtmf_low_idx_i, dtmf_high_idx_i;
  logic fast_data_o, slow_data_o, subaudible_strobe_out_o, high_group_strobe_out_o, low_group_strobe_out_o;
  logic alert_strobe_out_o, amp_en_o, ext_spk_sel_n_o, spi_sck_o, spi_mosi_o, spi_cs_n_o;
  rtas_pkg::rtas_opt_mode_t opt_mode_o;
  wire fast_data_in_i, slow_data_in_i;
  logic [15:0] word;
  logic [31:0] exp_q [$];
  int mismatches = 0, compares = 0, cyc = 0, n, m;
  int lf[4] = '{697, 770, 852, 941};
  int hf[4] = '{1209, 1336, 1477, 1477};
  wire [3:0] st = {alert_strobe_out_o, low_group_strobe_out_o, high_group_strobe_out_o, subaudible_strobe_out_o};
  rtas_ctrl uut (.*);
  rtas_fic_model u_fic (.spi_sck_i(spi_sck_o), .spi_mosi_i(spi_mosi_o), .spi_cs_n_i(spi_cs_n_o),
    .fd_raw_i(fd_raw), .sd_raw_i(sd_raw), .fdat_o(fast_data_in_i), .sdat_o(slow_data_in_i),
    .word_o(word), .word_stb_o(stb));
  function automatic int hp(int f, int k);
    return 50000000 / (2 * k * f);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, g, x);
    end
  endtask
  task automatic ex(input logic [15:0] w[$]);
    foreach (w[i]) exp_q.push_back(w[i]);
    repeat (2000) if (exp_q.size() != 0) @(negedge clk_i);
  endtask
  task automatic half(input int k, output int h);
    logic s;
    for (int p = 0; p < 2; p++) begin
      h = 0;
      s = st[k];
      while (st[k] === s && h < 300000) begin
        @(negedge clk_i);
        h++;
      end
    end
  endtask
  task automatic pulse_vol(input logic [7:0] x);
    volume_sense_in_i = x;
    volume_valid_i = 1;
    @(negedge clk_i);
    volume_valid_i = 0;
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 110000) begin
      mismatches++;
      summarize();
    end
  end
  always @(negedge clk_i) if (cyc > 20) {fd_raw, sd_raw} <= 2'($urandom);
  initial begin
    @(posedge nrst_i);
    forever begin
      @(stb);
      chk(word, exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF);
    end
  end
  initial begin
    {sub_tone_en_i, sub_code_en_i, sub_decode_en_i, dtmf_en_i, fast_data_en_i, alert_ext_en_i, alert_int_en_i,
      volume_valid_i, constant_volume_mode_i, vehicular_adapter_i, squelch_detect_i, sub_half_i, samp_half_i,
      baud_half_i, alert_half_i, dev_level_i, alert_level_i, volume_sense_in_i, cvc_level_i, ext_fixed_level_i,
      txd_gain_i, dtmf_low_idx_i, dtmf_high_idx_i} = '0;
    {option_line_a_i, option_line_b_i, fd_raw, sd_raw, nrst_i} = 5'h1E;
    void'($urandom(32'h38E7B325));
    repeat (10) @(negedge clk_i);
    nrst_i = 1;
    for (int i = 0; i < 4; i++) begin
      {option_line_a_i, option_line_b_i} = 2'(i);
      repeat (6) @(negedge clk_i);
      chk(opt_mode_o, i);
      chk(ext_spk_sel_n_o, i != 1);
    end
    samp_half_i = 20'h5;
    sub_decode_en_i = 1;
    half(0, n);
    chk(n, hp(2000, 1));
    sub_decode_en_i = 0;
    v = $urandom;
    c = v ^ 8'(1 + $urandom % 255);
    e = c ^ 8'(1 + $urandom % 255);
    pulse_vol(v);
    squelch_detect_i = 1;
    ex('{16'h0401, {8'h05, v}});
    repeat (4) @(negedge clk_i);
    chk({amp_en_o, ext_spk_sel_n_o}, 2'b11);
    cvc_level_i = c;
    constant_volume_mode_i = 1;
    ex('{{8'h05, c}});
    pulse_vol(~v);
    repeat (300) @(negedge clk_i);
    chk(amp_en_o, 1);
    ext_fixed_level_i = e;
    vehicular_adapter_i = 1;
    ex('{16'h0405, {8'h05, e}});
    repeat (4) @(negedge clk_i);
    chk({amp_en_o, ext_spk_sel_n_o}, 2'b10);
    vehicular_adapter_i = 0;
    ex('{16'h0401, {8'h05, c}});
    alert_level_i = v;
    alert_half_i = 20'(8333 + $urandom % 64);
    alert_ext_en_i = 1;
    ex('{16'h0403, {8'h05, v}});
    half(3, n);
    chk(n, alert_half_i);
    {alert_ext_en_i, alert_int_en_i} = 2'b01;
    repeat (4) @(negedge clk_i);
    chk({st[3], amp_en_o}, 2'b01);
    alert_int_en_i = 0;
    ex('{16'h0401, {8'h05, c}});
    txd_gain_i = 6'($urandom);
    dtmf_en_i = 1;
    ex('{{8'h03, txd_gain_i, 2'b10}});
    for (int k = 0; k < 4; k++) begin
      {dtmf_low_idx_i, dtmf_high_idx_i} = {2'(k), 2'(k)};
      fork
        half(1, n);
        half(2, m);
      join
      chk(m, hp(lf[k], 6));
      chk(n, hp(hf[k], hf[k] < 1440 ? 6 : 2));
    end
    baud_half_i = 20'(24 + $urandom % 40);
    {dtmf_en_i, fast_data_en_i} = 2'b01;
    ex('{{8'h03, txd_gain_i, 2'b01}});
    half(1, n);
    chk(n, baud_half_i);
    dev_level_i = e;
    sub_half_i = 20'(16 + $urandom % 48);
    sub_tone_en_i = 1;
    ex('{{8'h01, e}, 16'h0201});
    half(0, n);
    chk(n, sub_half_i);
    sub_code_en_i = 1;
    repeat (300) @(negedge clk_i);
    sub_tone_en_i = 0;
    ex('{16'h0202});
    half(0, n);
    chk(n, sub_half_i);
    chk(exp_q.size(), 0);
    summarize();
  end
endmodule
